// ==== hw/cbb_pkg.sv ====
package cbb_pkg;

  // clock and timing figures; times in their own unit, counts derived
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_FILTER_TIME_NS = 1000;
  localparam int BUS_IDLE_TIMEOUT_US = 1000;
  localparam int WAKE_TIMEOUT_US = 1000;
  // least times round up to whole cycles
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_IDLE_TIMEOUT_CYC =
    (BUS_IDLE_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // a longest time rounds down
  localparam int WAKE_TIMEOUT_CYC = (WAKE_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  // rxd reset value and rxd idle level
  localparam logic RXD_IDLE = 1'h1;

  // operating mode as presented on the mode input
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_SILENT,
    MODE_STANDBY,
    MODE_GOSLEEP,
    MODE_SLEEP
  } cbb_mode_t;

  // bias state of the bus side
  typedef enum logic [1:0] {
    BIAS_OFF,
    BIAS_AUTO_INACT,
    BIAS_AUTO_ACT,
    BIAS_ACTIVE
  } cbb_bias_t;

  // supply undervoltage flags; fall = below falling threshold, rise = above rising
  typedef struct packed {
    logic hvSupplyFallFlag;
    logic hvSupplyRiseFlag;
    logic xcvrSupplyFallFlag;
    logic xcvrSupplyRiseFlag;
    logic logicSupplyFallFlag;
    logic logicSupplyRiseFlag;
  } cbb_supply_t;

  // analog front-end controls
  typedef struct packed {
    logic xcvrOn;
    logic biasMid;
    logic biasGnd;
    logic normalRxOn;
    logic wakeRxOn;
  } cbb_front_t;

endpackage

// ==== hw/cbb_sync3.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbb_sync3
  import cbb_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("cbb_sync3: WIDTH must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // three stage flops and a hold flop per bit; a change counts once the last two stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic [2:0] stage;
      logic held;
      // stage[0] feeds stage[1] only, so metastability never reaches logic
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          stage <= 3'h0;
          held <= 1'h0;
        end
        else
        begin
          stage <= {stage[1:0], asyncIn[i]};
          if (stage[1] == stage[2])
          begin
            held <= stage[2];
          end
        end
      end
      assign syncOut[i] = held;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== hw/cbb_wake_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbb_wake_detect
  import cbb_pkg::*;
#(
  parameter int FILTER_CYC = WAKE_FILTER_CYC,
  parameter int TIMEOUT_CYC = WAKE_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic busDominant,
  output logic remoteWakePattern
);

  localparam int RW = $clog2(FILTER_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [RW-1:0] RUN_LAST = RW'(FILTER_CYC - 1);
  localparam logic [RW-1:0] RUN_MAX = RW'(FILTER_CYC);
  localparam logic [TW-1:0] TIME_MAX = TW'(TIMEOUT_CYC);

  generate
    if (FILTER_CYC < 1 || TIMEOUT_CYC <= 3 * FILTER_CYC)
    begin : g_chk
      $error("cbb_wake_detect: timeout must exceed three filter times");
    end
  endgenerate

  typedef enum logic [1:0] {W_IDLE, W_DOM1, W_REC} cbb_wstate_t;
  cbb_wstate_t wState;
  cbb_wstate_t next_wState;
  logic lastDom;
  logic [RW-1:0] runCnt;
  logic [TW-1:0] timeCnt;

  ////////////////////////////////////////////////////////////////////////////
  // filtered edge: the cycle a steady bus level first reaches the filter time
  wire sameLevel = (busDominant == lastDom);
  wire filtHit = sameLevel && (runCnt == RUN_LAST);
  wire domHit = filtHit && busDominant;
  wire recHit = filtHit && !busDominant;
  wire expired = (wState != W_IDLE) && (timeCnt == TIME_MAX);
  wire patternDone = (wState == W_REC) && domHit && !expired;

  // other traffic between phases never resets the monitor, only the timeout
  always_comb
  begin
    next_wState = wState;
    unique case (wState)
      W_IDLE: if (domHit) next_wState = W_DOM1;
      W_DOM1: if (recHit) next_wState = W_REC;
      W_REC: if (domHit) next_wState = W_IDLE;
    endcase
    if (expired)
    begin
      next_wState = W_IDLE;
    end
  end

  // a bus held dominant over the timeout needs a recessive before a new pattern
  always_ff @(posedge clk)
  begin
    if (sys_rst || !enable)
    begin
      wState <= W_IDLE;
      lastDom <= 1'h0;
      runCnt <= '0;
      timeCnt <= '0;
      remoteWakePattern <= 1'h0;
    end
    else
    begin
      wState <= next_wState;
      lastDom <= busDominant;
      runCnt <= !sameLevel ? RW'(1) : (runCnt == RUN_MAX ? runCnt : runCnt + RW'(1));
      timeCnt <= (next_wState == W_IDLE) ? '0 : timeCnt + TW'(1);
      remoteWakePattern <= patternDone;
    end
  end

endmodule
`default_nettype wire

// ==== hw/cbb_bias_ctrl.sv ====
// Function
// - exactly one of four bias states
// - off state: transceiver off, bus floating
// - high-voltage supply fall forces off
// - off to autonomous inactive on supply rise
// - autonomous inactive biases bus to ground
// - remote wake biases mid, autonomous active
// - no normal mode before timeout: inactive
// - low-power entry picks autonomous state by idle
// - active to autonomous active: short idle, undervoltage
// - inactive to active-auto: wake or undervoltage entry
// - autonomous active to inactive after idle timeout
// - normal/silent means active; silent disables driver
// - normal with healthy supplies enters active
// - transmit low before leaving standby blocks driver
// - active to inactive on long idle
// - dominant means low transmit and receive
// - recessive means high; high transmit drives nothing
// - bus outputs undriven except normal mode
// - wake detection off in normal or silent
// - sleep modes use low-power wake receiver
// - standby receive high, low while wake persists
// - dominant overrides recessive during arbitration
// - wake needs dominant, recessive, dominant filtered
`timescale 1ns/1ps
`default_nettype none
module cbb_bias_ctrl
  import cbb_pkg::*;
#(
  parameter int IDLE_CYC = BUS_IDLE_TIMEOUT_CYC,
  parameter int WAKE_TO_CYC = WAKE_TIMEOUT_CYC,
  parameter int FILTER_CYC = WAKE_FILTER_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire cbb_supply_t supplyFlags,
  input wire logic [2:0] opMode,
  input wire logic txdIn,
  input wire logic busDominant,
  output cbb_bias_t biasState,
  output cbb_front_t frontCtl,
  output logic busDrive,
  output logic rxdOut,
  output logic txStuckLowBlock,
  output logic busIdleTimeout,
  output logic remoteWakePattern
);

  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam logic [IW-1:0] IDLE_MAX = IW'(IDLE_CYC);

  generate
    if (IDLE_CYC < 1)
    begin : g_chk
      $error("cbb_bias_ctrl: IDLE_CYC must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // every outside level crosses through four flops before use
  localparam int SW = $bits(cbb_supply_t) + 5;
  logic [SW-1:0] syncVec;
  cbb_supply_t sup;
  logic [2:0] modeBits;
  logic txdSync;
  logic busDom;

  cbb_sync3 #(.WIDTH(SW)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({supplyFlags, opMode, txdIn, busDominant}),
    .syncOut(syncVec)
  );

  assign sup = cbb_supply_t'(syncVec[SW-1:5]);
  assign modeBits = syncVec[4:2];
  assign txdSync = syncVec[1];
  assign busDom = syncVec[0];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode; unused codes count as low power, the safe side
  wire modeNormal = (modeBits == MODE_NORMAL);
  wire modeSilent = (modeBits == MODE_SILENT);
  wire modeActive = modeNormal || modeSilent;
  wire lowPower = !modeActive;
  wire modeStandby = (modeBits == MODE_STANDBY);
  wire lvFall = sup.xcvrSupplyFallFlag || sup.logicSupplyFallFlag;
  wire lvGood = sup.xcvrSupplyRiseFlag && sup.logicSupplyRiseFlag && !lvFall;
  wire txLow = !txdSync;

  ////////////////////////////////////////////////////////////////////////////
  // bus-silence timer: any dominant restarts it, saturates at the limit
  logic [IW-1:0] idleCnt;
  always_ff @(posedge clk)
  begin
    if (sys_rst || busDom)
    begin
      idleCnt <= '0;
    end
    else if (idleCnt != IDLE_MAX)
    begin
      idleCnt <= idleCnt + IW'(1);
    end
  end
  assign busIdleTimeout = (idleCnt == IDLE_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // wake pattern monitor, off in the active modes and while unpowered
  wire wakeEnable = lowPower && (biasState != BIAS_OFF);

  cbb_wake_detect #(.FILTER_CYC(FILTER_CYC), .TIMEOUT_CYC(WAKE_TO_CYC)) u_wake (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(wakeEnable),
    .busDominant(busDom),
    .remoteWakePattern(remoteWakePattern)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bias state machine; supply loss has priority over everything
  cbb_bias_t next_biasState;
  always_comb
  begin
    next_biasState = biasState;
    unique case (biasState)
      BIAS_OFF:
        if (sup.hvSupplyRiseFlag) next_biasState = BIAS_AUTO_INACT;
      BIAS_AUTO_INACT:
        if (modeActive && lvGood) next_biasState = BIAS_ACTIVE;
        else if (modeActive && lvFall) next_biasState = BIAS_AUTO_ACT;
        else if (remoteWakePattern) next_biasState = BIAS_AUTO_ACT;
      BIAS_AUTO_ACT:
        if (modeActive && lvGood) next_biasState = BIAS_ACTIVE;
        else if (lowPower && busIdleTimeout) next_biasState = BIAS_AUTO_INACT;
      BIAS_ACTIVE:
        if (lvFall) next_biasState = BIAS_AUTO_ACT;
        else if (lowPower && busIdleTimeout) next_biasState = BIAS_AUTO_INACT;
        else if (lowPower) next_biasState = BIAS_AUTO_ACT;
    endcase
    if (sup.hvSupplyFallFlag)
    begin
      next_biasState = BIAS_OFF;
    end
  end

  // single encoded register, so only one state can ever be held
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      biasState <= BIAS_OFF;
    end
    else
    begin
      biasState <= next_biasState;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front-end controls follow the state and mode
  assign frontCtl.xcvrOn = (biasState != BIAS_OFF);
  assign frontCtl.biasMid = (biasState == BIAS_AUTO_ACT) || (biasState == BIAS_ACTIVE);
  assign frontCtl.biasGnd = (biasState == BIAS_AUTO_INACT);
  assign frontCtl.normalRxOn = (biasState == BIAS_ACTIVE) && modeActive;
  assign frontCtl.wakeRxOn = (biasState != BIAS_OFF) && lowPower;

  ////////////////////////////////////////////////////////////////////////////
  // stuck-low transmit guard: armed on entry to active, freed by a high level
  wire enterActive = (next_biasState == BIAS_ACTIVE) && (biasState != BIAS_ACTIVE);
  wire blockSet = enterActive && txLow;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txStuckLowBlock <= 1'h0;
    end
    else if (blockSet)
    begin
      txStuckLowBlock <= 1'h1;
    end
    else if (!txLow)
    begin
      txStuckLowBlock <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake event holds until an active mode is requested or the bias is off; a new hit wins
  logic wakePending;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wakePending <= 1'h0;
    end
    else if (remoteWakePattern)
    begin
      wakePending <= 1'h1;
    end
    else if (modeActive || biasState == BIAS_OFF)
    begin
      wakePending <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // only normal mode drives; a bus open drain lets any dominant node win
  wire next_busDrive = (biasState == BIAS_ACTIVE) && modeNormal && txLow
    && !txStuckLowBlock && !blockSet;
  // receive pin: bus level when active, else wake indication only
  wire next_rxd = frontCtl.normalRxOn ? !busDom
    : (frontCtl.wakeRxOn ? !wakePending : RXD_IDLE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busDrive <= 1'h0;
      rxdOut <= RXD_IDLE;
    end
    else
    begin
      busDrive <= next_busDrive;
      rxdOut <= next_rxd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  hv_fall_off_a: assert property (sup.hvSupplyFallFlag |=> biasState == BIAS_OFF)
    else $error("supply fall did not force off");
  off_rise_inact_a: assert property (biasState == BIAS_OFF && sup.hvSupplyRiseFlag
    && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_INACT)
    else $error("off did not leave on supply rise");
  off_floating_a: assert property (biasState == BIAS_OFF |-> !frontCtl.xcvrOn
    && !frontCtl.biasMid && !frontCtl.biasGnd && !busDrive)
    else $error("bus loaded while off");
  inact_gnd_a: assert property (biasState == BIAS_AUTO_INACT |-> frontCtl.biasGnd
    && !frontCtl.biasMid)
    else $error("inactive state not ground biased");
  wake_to_act_a: assert property (biasState == BIAS_AUTO_INACT && remoteWakePattern
    && !modeActive && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_ACT
    && frontCtl.biasMid)
    else $error("wake did not reach autonomous active");
  idle_to_inact_a: assert property (biasState == BIAS_AUTO_ACT && lowPower
    && busIdleTimeout && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_INACT)
    else $error("idle timeout ignored in autonomous active");
  active_uv_a: assert property (biasState == BIAS_ACTIVE && lvFall
    && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_ACT)
    else $error("undervoltage did not leave active");
  active_long_a: assert property (biasState == BIAS_ACTIVE && lowPower && !lvFall
    && busIdleTimeout && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_INACT)
    else $error("long idle did not reach inactive");
  enter_active_a: assert property (biasState inside {BIAS_AUTO_INACT, BIAS_AUTO_ACT}
    && modeNormal && lvGood && !sup.hvSupplyFallFlag |=> biasState == BIAS_ACTIVE)
    else $error("normal mode did not enter active");
  no_drive_a: assert property (!modeNormal |=> !busDrive)
    else $error("bus driven outside normal mode");
  block_hold_a: assert property (txStuckLowBlock && txLow |=> txStuckLowBlock
    && !busDrive)
    else $error("stuck transmit block released early");
  wake_quiet_a: assert property (modeActive [*3] |-> !remoteWakePattern)
    else $error("wake detected in active mode");
  rxd_dom_a: assert property (frontCtl.normalRxOn && busDom |=> !rxdOut)
    else $error("receive pin not low on dominant");
  idle_restart_a: assert property (busDom |=> !busIdleTimeout)
    else $error("idle flag survived bus activity");

  // mode-dependent pins, bias outputs and transitions; these catch a decode slip the bench may miss
  silent_no_drive_a: assert property (biasState == BIAS_ACTIVE && modeSilent
    |=> !busDrive)
    else $error("bus driven in silent mode");
  active_bias_a: assert property (biasState == BIAS_ACTIVE |-> frontCtl.biasMid
    && frontCtl.xcvrOn)
    else $error("active state not mid biased");
  inact_uv_a: assert property (biasState == BIAS_AUTO_INACT && modeActive && lvFall
    && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_ACT)
    else $error("undervoltage entry did not reach autonomous active");
  active_short_a: assert property (biasState == BIAS_ACTIVE && lowPower && !lvFall
    && !busIdleTimeout && !sup.hvSupplyFallFlag |=> biasState == BIAS_AUTO_ACT)
    else $error("short idle did not keep the bias up");
  sleep_rx_a: assert property (biasState != BIAS_OFF && lowPower
    |-> frontCtl.wakeRxOn && !frontCtl.normalRxOn)
    else $error("wake receiver not selected in low power");
  standby_high_a: assert property (frontCtl.wakeRxOn && !wakePending
    |=> rxdOut)
    else $error("receive pin low without a wake event");
  standby_low_a: assert property (frontCtl.wakeRxOn && wakePending
    |=> !rxdOut)
    else $error("receive pin high while wake persists");

  wake_seen_c: cover property (remoteWakePattern ##1 biasState == BIAS_AUTO_ACT);
  go_active_c: cover property (biasState == BIAS_AUTO_ACT ##1 biasState == BIAS_ACTIVE);
  tx_block_c: cover property (blockSet ##1 txStuckLowBlock [*2] ##1 !txStuckLowBlock);
  timeout_c: cover property (biasState == BIAS_AUTO_ACT ##1 biasState == BIAS_AUTO_INACT);

endmodule
`default_nettype wire

// ==== tb/cbb_can_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbb_can_ctrl_model
  import cbb_pkg::*;
(
  input wire logic clk,
  input wire logic txEnable,
  input wire logic txBit,
  input wire logic otherDom,
  input wire logic devDrive,
  output logic txdIn,
  output logic busDom
);
  ////////////////////////////////////////////////////////////////////////////////
  // controller transmit pin: low sends dominant, a released pin is pulled high
  assign txdIn = txEnable ? txBit : 1'h1;
  // wired bus: any node driving dominant wins over every recessive node
  assign busDom = devDrive | otherDom;
endmodule
`default_nettype wire

// ==== tb/test_can_bus_bias_state_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_can_bus_bias_state_control
  import cbb_pkg::*;
;
  localparam logic [5:0] SUP_GOOD = 6'h15;
  localparam logic [5:0] SUP_XCVR_LOW = 6'h19;
  localparam logic [5:0] SUP_HV_LOW = 6'h20;
  logic clk;
  logic sys_rst;
  logic [5:0] supplyFlags;
  logic [2:0] opMode;
  logic txEnable;
  logic txBit;
  logic otherDom;
  logic txdIn;
  logic busDom;
  cbb_bias_t biasState;
  cbb_front_t frontCtl;
  logic busDrive;
  logic rxdOut;
  logic txStuckLowBlock;
  logic busIdleTimeout;
  logic remoteWakePattern;
  int wakeCount;
  int wakeBase;
  logic [7:0] rnd;
  int err_total;
  int check_count;
  ////////////////////////////////////////////////////////////////////////////////
  cbb_bias_ctrl #(.IDLE_CYC(50), .WAKE_TO_CYC(64), .FILTER_CYC(4)) u_cbb_bias_ctrl (
    .clk(clk), .sys_rst(sys_rst), .supplyFlags(supplyFlags), .opMode(opMode),
    .txdIn(txdIn), .busDominant(busDom), .biasState(biasState), .frontCtl(frontCtl),
    .busDrive(busDrive), .rxdOut(rxdOut), .txStuckLowBlock(txStuckLowBlock),
    .busIdleTimeout(busIdleTimeout), .remoteWakePattern(remoteWakePattern));
  cbb_can_ctrl_model u_cbb_can_ctrl_model (
    .clk(clk), .txEnable(txEnable), .txBit(txBit), .otherDom(otherDom),
    .devDrive(busDrive), .txdIn(txdIn), .busDom(busDom));
  ////////////////////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // the wake pulse lasts one cycle, so count pulses for later checks
  always @(posedge clk)
  begin
    if (sys_rst)
      wakeCount <= 0;
    else if (remoteWakePattern === 1'h1)
      wakeCount <= wakeCount + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // only normal mode with a low, unblocked transmit pin drives the bus
  function automatic logic exp_drive(input logic [2:0] m, input logic txd, input logic blk);
    return (m == 3'(MODE_NORMAL)) && !txd && !blk;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input cbb_bias_t got, input cbb_bias_t exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t state got %h expected %h", $time, got, exp);
    end
  endtask
  // inputs change one nanosecond after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait; a visit to the forbidden state is reported as that state
  task automatic wait_state(input cbb_bias_t exp, input cbb_bias_t bad, input int maxc);
    int n;
    logic hitBad;
    n = 0;
    hitBad = 1'h0;
    while (biasState !== exp && n < maxc)
    begin
      if (biasState === bad && bad != exp) hitBad = 1'h1;
      tick(1);
      n++;
    end
    chk_state(hitBad ? bad : biasState, exp);
  endtask
  // dominant, recessive, dominant, each twice the filter length
  task automatic send_wake();
    otherDom = 1'h1;
    tick(8);
    otherDom = 1'h0;
    tick(8);
    otherDom = 1'h1;
    tick(8);
    otherDom = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    err_total = 0;
    check_count = 0;
    sys_rst = 1'h1;
    supplyFlags = 6'h00;
    opMode = MODE_STANDBY;
    txEnable = 1'h0;
    txBit = 1'h1;
    otherDom = 1'h0;
    wakeBase = 0;
    rnd = 8'h24;
    tick(12);
    chk_state(biasState, BIAS_OFF);
    chk_bit(frontCtl.xcvrOn | frontCtl.biasGnd | frontCtl.biasMid, 1'h0);
    chk_bit(rxdOut, 1'h1);
    sys_rst = 1'h0;
    supplyFlags = SUP_GOOD;
    wait_state(BIAS_AUTO_INACT, BIAS_AUTO_INACT, 12);
    chk_bit(frontCtl.biasGnd, 1'h1);
    chk_bit(rxdOut, 1'h1);
    send_wake();
    wait_state(BIAS_AUTO_ACT, BIAS_AUTO_ACT, 10);
    chk_bit(wakeCount != 0, 1'h1);
    chk_bit(frontCtl.biasMid, 1'h1);
    tick(2);
    chk_bit(rxdOut, 1'h0);
    // controller stays silent past the idle timeout
    wait_state(BIAS_AUTO_INACT, BIAS_AUTO_INACT, 80);
    opMode = MODE_SLEEP;
    tick(8);
    chk_bit(frontCtl.wakeRxOn & ~frontCtl.normalRxOn, 1'h1);
    opMode = MODE_NORMAL;
    wait_state(BIAS_ACTIVE, BIAS_ACTIVE, 10);
    chk_bit(frontCtl.xcvrOn & frontCtl.normalRxOn, 1'h1);
    wakeBase = wakeCount;
    txEnable = 1'h1;
    send_wake();
    tick(8);
    chk_bit(wakeCount != wakeBase, 1'h0);
    // random transmit, foreign dominant and normal/silent mix
    repeat (16)
    begin
      rnd = lfsr_next(rnd);
      txBit = rnd[0];
      otherDom = rnd[1];
      opMode = rnd[2] ? MODE_SILENT : MODE_NORMAL;
      tick(12);
      chk_state(biasState, BIAS_ACTIVE);
      chk_bit(busDrive, exp_drive(opMode, txBit, 1'h0));
      chk_bit(rxdOut, ~(exp_drive(opMode, txBit, 1'h0) | otherDom));
    end
    txBit = 1'h1;
    otherDom = 1'h0;
    opMode = MODE_NORMAL;
    supplyFlags = SUP_XCVR_LOW;
    wait_state(BIAS_AUTO_ACT, BIAS_AUTO_ACT, 10);
    opMode = MODE_STANDBY;
    wait_state(BIAS_AUTO_INACT, BIAS_AUTO_INACT, 80);
    opMode = MODE_NORMAL;
    wait_state(BIAS_AUTO_ACT, BIAS_ACTIVE, 10);
    supplyFlags = SUP_GOOD;
    wait_state(BIAS_ACTIVE, BIAS_ACTIVE, 10);
    // recent activity, then low power: short idle keeps the bias up
    otherDom = 1'h1;
    tick(8);
    otherDom = 1'h0;
    opMode = MODE_STANDBY;
    wait_state(BIAS_AUTO_ACT, BIAS_AUTO_INACT, 10);
    opMode = MODE_NORMAL;
    wait_state(BIAS_ACTIVE, BIAS_ACTIVE, 10);
    tick(70);
    chk_bit(busIdleTimeout, 1'h1);
    opMode = MODE_GOSLEEP;
    wait_state(BIAS_AUTO_INACT, BIAS_AUTO_ACT, 10);
    // controller holds transmit low while leaving standby, on purpose
    opMode = MODE_STANDBY;
    txBit = 1'h0;
    tick(8);
    opMode = MODE_NORMAL;
    wait_state(BIAS_ACTIVE, BIAS_ACTIVE, 10);
    tick(8);
    chk_bit(txStuckLowBlock, 1'h1);
    chk_bit(busDrive, 1'h0);
    txBit = 1'h1; // release before driving again
    tick(8);
    chk_bit(txStuckLowBlock, 1'h0);
    txBit = 1'h0;
    tick(8);
    chk_bit(busDrive, exp_drive(opMode, txBit, 1'h0));
    txBit = 1'h1;
    supplyFlags = SUP_HV_LOW;
    wait_state(BIAS_OFF, BIAS_OFF, 10);
    tick(2);
    chk_bit(frontCtl.xcvrOn | busDrive, 1'h0);
    opMode = MODE_STANDBY;
    supplyFlags = SUP_GOOD;
    wait_state(BIAS_AUTO_INACT, BIAS_AUTO_INACT, 12);
    finish_test();
  end
endmodule
`default_nettype wire
